// File: verilog/uart_baud_top.sv
// Serial port with modulo baud generator, double buffered transmit and receive.
// Assumes an Avalon-MM master on CLK and an asynchronous serial line on RXD/TXD.
//
// Functional notes
// - Baud rate is clock over sixteen times divisor.
// - Zero divisor stops the baud generator.
// - Divisor high five bits, low eight bits.
// - High byte buffered, applied on low write.
// - Low divisor resets to nonzero value.
// - Generator idle until receiver or transmitter enabled.
// - Transmitter and receiver share one baud rate.
// - Each instance owns its own generator.
// - Break detect flag interrupts when enabled.
// - Receive edge flag interrupts when enabled.
// - Thirteen bit break sent, eleven detected.
// - Eight or nine data bits selectable.
// - Double buffers, separate receiver and transmitter enables.
// - Overrun, parity, framing and noise flagged.
// - Transmit empty and complete flags provided.
// - Receiver wakeup by idle or address mark.
// - Transmit output polarity can be inverted.
// - NRZ framing, full duplex operation.
`timescale 1ns/1ps
`include "uart_baud_defs.svh"
module uart_baud_top
  import uart_baud_pkg::*;
(
  // Clock and reset.
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  // Avalon-MM slave.
  input  wire logic [`ADDR_WIDTH-1:0] AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  output logic [31:0]                 AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  // Serial line.
  input  wire logic                   RXD,
  output logic                        TXD,
  // Interrupt request.
  output logic                        IRQ
);
  logic                  brk_ie_reg, edge_ie_reg;
  logic [4:0]            div_hi_buf_reg, div_hi_reg;
  logic [7:0]            div_lo_reg;
  logic                  nine_reg, wake_addr_reg, par_en_reg, par_odd_reg;
  logic                  tie_reg, tcie_reg, rie_reg, te_reg, re_reg, rwu_reg, sbk_reg;
  logic                  tx_inv_reg, brk_long_reg, started_reg;
  logic                  tdre_reg, tc_reg, rdrf_reg, idle_reg, ovr_reg, noise_reg;
  logic                  frame_reg, par_reg, brk_flag_reg, edge_flag_reg;
  logic [8:0]            tx_hold_reg, rx_data_reg;
  logic                  rd_ack_reg;
  logic [31:0]           rdata_next;
  logic                  wr_en, rd_en, tick;
  logic [`DIV_WIDTH-1:0] baud_divisor_value;
  logic                  rx_meta_reg, rx_sync_reg, rx_prev_reg;
  rx_state_e             rx_state_reg;
  logic [3:0]            rx_scnt_reg, rx_bcnt_reg;
  logic [1:0]            rx_ones_reg;
  logic                  rx_noise_reg;
  logic [8:0]            rx_shift_reg;
  logic [7:0]            low_cnt_reg, high_cnt_reg;
  logic                  idle_armed_reg;
  tx_state_e             tx_state_reg;
  logic [3:0]            tx_scnt_reg, tx_bcnt_reg;
  logic [10:0]           tx_shift_reg;
  logic                  txd_reg;

  assign wr_en = AVS_WRITE && AVS_BYTEENABLE[0];
  assign rd_en = AVS_READ && !rd_ack_reg;
  assign AVS_WAITREQUEST = AVS_READ && !rd_ack_reg;

  assign baud_divisor_value = {div_hi_reg, div_lo_reg};

  uart_baud_gen #(
    .DIV_W   (`DIV_WIDTH)
  ) u_baud (
    .clk     (CLK),
    .rst     (SYS_RST),
    .run     (started_reg),
    .divisor (baud_divisor_value),
    .tick    (tick)
  );

  // Receive datapath decodes.
  logic       bit_val, bit_noisy, rx_done, rx_fall, brk_set, idle_set;
  logic [8:0] rx_word;
  logic       rx_msb, rx_par_bad, rx_accept, wake_evt;
  assign bit_val    = rx_ones_reg[1];
  assign bit_noisy  = rx_ones_reg != 2'h0 && rx_ones_reg != 2'h3;
  assign rx_done    = tick && rx_state_reg == RX_STOP && rx_scnt_reg == `OVS_LAST;
  assign rx_word    = nine_reg ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  assign rx_msb     = nine_reg ? rx_word[8] : rx_word[7];
  assign rx_par_bad = par_en_reg && ((^rx_word) != par_odd_reg);
  assign rx_fall    = rx_prev_reg && !rx_sync_reg;
  assign brk_set    = tick && re_reg && low_cnt_reg == `BREAK_RX_TICKS;
  assign idle_set   = tick && re_reg && idle_armed_reg
                      && high_cnt_reg == (nine_reg ? `IDLE_TICKS_9 : `IDLE_TICKS_8);
  assign wake_evt   = rwu_reg && (wake_addr_reg ? (rx_done && rx_msb) : idle_set);
  assign rx_accept  = rx_done && (!rwu_reg || wake_evt);

  // Transmit decodes.
  logic tx_load, tx_end, tx_bit_end, data_wr, data_rd;
  assign data_wr    = wr_en && AVS_ADDRESS == `ADDR_DATA;
  assign data_rd    = rd_en && AVS_ADDRESS == `ADDR_DATA;
  assign tx_bit_end = tick && tx_scnt_reg == `OVS_LAST;
  assign tx_load    = tick && tx_state_reg == TX_IDLE && te_reg && !sbk_reg && !tdre_reg;
  assign tx_end     = tx_bit_end && tx_state_reg != TX_IDLE
                      && tx_bcnt_reg == (tx_state_reg == TX_BREAK
                         ? ((brk_long_reg ? `BREAK_TX_LONG : `BREAK_TX_SHORT) - 4'h1)
                         : ((nine_reg ? `FRAME_BITS_9 : `FRAME_BITS_8) - 4'h1));

  // Divisor and interrupt enable registers.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      brk_ie_reg     <= 1'b0;
      edge_ie_reg    <= 1'b0;
      div_hi_buf_reg <= `DIV_HIGH_RESET;
      div_hi_reg     <= `DIV_HIGH_RESET;
      div_lo_reg     <= `DIV_LOW_RESET;
    end else if (wr_en && AVS_ADDRESS == `ADDR_DIV_HIGH) begin
      brk_ie_reg     <= AVS_WRITEDATA[`HI_BRK_IE];
      edge_ie_reg    <= AVS_WRITEDATA[`HI_EDGE_IE];
      div_hi_buf_reg <= AVS_WRITEDATA[4:0];
    end else if (wr_en && AVS_ADDRESS == `ADDR_DIV_LOW) begin
      div_lo_reg     <= AVS_WRITEDATA[7:0];
      div_hi_reg     <= div_hi_buf_reg;
    end
  end

  // Control registers.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      nine_reg      <= 1'b0;
      wake_addr_reg <= 1'b0;
      par_en_reg    <= 1'b0;
      par_odd_reg   <= 1'b0;
      tie_reg       <= 1'b0;
      tcie_reg      <= 1'b0;
      rie_reg       <= 1'b0;
      te_reg        <= 1'b0;
      re_reg        <= 1'b0;
      sbk_reg       <= 1'b0;
      tx_inv_reg    <= 1'b0;
      brk_long_reg  <= 1'b1;
    end else if (wr_en) begin
      if (AVS_ADDRESS == `ADDR_CTRL_ONE) begin
        nine_reg      <= AVS_WRITEDATA[`C1_NINE];
        wake_addr_reg <= AVS_WRITEDATA[`C1_WAKE_ADDR];
        par_en_reg    <= AVS_WRITEDATA[`C1_PAR_EN];
        par_odd_reg   <= AVS_WRITEDATA[`C1_PAR_ODD];
      end
      if (AVS_ADDRESS == `ADDR_CTRL_TWO) begin
        tie_reg  <= AVS_WRITEDATA[`C2_TIE];
        tcie_reg <= AVS_WRITEDATA[`C2_TCIE];
        rie_reg  <= AVS_WRITEDATA[`C2_RIE];
        te_reg   <= AVS_WRITEDATA[`C2_TE];
        re_reg   <= AVS_WRITEDATA[`C2_RE];
        sbk_reg  <= AVS_WRITEDATA[`C2_SBK];
      end
      if (AVS_ADDRESS == `ADDR_STAT_TWO) begin
        tx_inv_reg   <= AVS_WRITEDATA[`S2_TX_INV];
        brk_long_reg <= AVS_WRITEDATA[`S2_BRK_LONG];
      end
    end
  end

  // Standby bit: hardware wakeup beats a software write.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rwu_reg <= 1'b0;
    end else if (wake_evt) begin
      rwu_reg <= 1'b0;
    end else if (wr_en && AVS_ADDRESS == `ADDR_CTRL_TWO) begin
      rwu_reg <= AVS_WRITEDATA[`C2_RWU];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      started_reg <= 1'b0;
    end else if (wr_en && AVS_ADDRESS == `ADDR_CTRL_TWO
                 && (AVS_WRITEDATA[`C2_TE] || AVS_WRITEDATA[`C2_RE])) begin
      started_reg <= 1'b1;
    end
  end

  // Transmit holding register.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_hold_reg <= 9'h000;
    end else if (data_wr) begin
      tx_hold_reg <= {AVS_WRITEDATA[8] && AVS_BYTEENABLE[1], AVS_WRITEDATA[7:0]};
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tdre_reg <= 1'b1;
      tc_reg   <= 1'b1;
    end else begin
      if (tx_load) begin
        tdre_reg <= 1'b1;
      end else if (data_wr) begin
        tdre_reg <= 1'b0;
      end
      if (tx_end && tdre_reg && !tx_load) begin
        tc_reg <= 1'b1;
      end else if (data_wr) begin
        tc_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdrf_reg    <= 1'b0;
      ovr_reg     <= 1'b0;
      noise_reg   <= 1'b0;
      frame_reg   <= 1'b0;
      par_reg     <= 1'b0;
      idle_reg    <= 1'b0;
      rx_data_reg <= 9'h000;
    end else begin
      if (rx_accept && !rdrf_reg) begin
        rdrf_reg    <= 1'b1;
        rx_data_reg <= rx_word;
      end else if (data_rd) begin
        rdrf_reg <= 1'b0;
      end
      if (rx_accept && rdrf_reg) begin
        ovr_reg <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == `ADDR_STAT_ONE && AVS_WRITEDATA[`S1_OVR]) begin
        ovr_reg <= 1'b0;
      end
      if (rx_accept && (rx_noise_reg || bit_noisy)) begin
        noise_reg <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == `ADDR_STAT_ONE && AVS_WRITEDATA[`S1_NOISE]) begin
        noise_reg <= 1'b0;
      end
      if (rx_accept && !bit_val) begin
        frame_reg <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == `ADDR_STAT_ONE && AVS_WRITEDATA[`S1_FRAME]) begin
        frame_reg <= 1'b0;
      end
      if (rx_accept && rx_par_bad) begin
        par_reg <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == `ADDR_STAT_ONE && AVS_WRITEDATA[`S1_PAR]) begin
        par_reg <= 1'b0;
      end
      if (idle_set && !rwu_reg) begin
        idle_reg <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == `ADDR_STAT_ONE && AVS_WRITEDATA[`S1_IDLE]) begin
        idle_reg <= 1'b0;
      end
    end
  end

  // Break and edge flags, set wins over a write-one clear.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      brk_flag_reg  <= 1'b0;
      edge_flag_reg <= 1'b0;
    end else begin
      if (brk_set) begin
        brk_flag_reg <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == `ADDR_STAT_TWO && AVS_WRITEDATA[`S2_BRK_FLAG]) begin
        brk_flag_reg <= 1'b0;
      end
      if (rx_fall && re_reg) begin
        edge_flag_reg <= 1'b1;
      end else if (wr_en && AVS_ADDRESS == `ADDR_STAT_TWO && AVS_WRITEDATA[`S2_EDGE_FLAG]) begin
        edge_flag_reg <= 1'b0;
      end
    end
  end

  // Receive pin synchroniser.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= RXD;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Line level run counters for break and idle detection.
  always_ff @(posedge CLK) begin
    if (SYS_RST || !re_reg) begin
      low_cnt_reg    <= 8'h00;
      high_cnt_reg   <= 8'h00;
      idle_armed_reg <= 1'b0;
    end else begin
      if (rx_done) begin
        idle_armed_reg <= 1'b1;
      end else if (idle_set) begin
        idle_armed_reg <= 1'b0;
      end
      if (tick) begin
        low_cnt_reg  <= rx_sync_reg ? 8'h00 : low_cnt_reg + {7'h00, low_cnt_reg != 8'hFF};
        high_cnt_reg <= !rx_sync_reg ? 8'h00 : high_cnt_reg + {7'h00, high_cnt_reg != 8'hFF};
      end
    end
  end

  // NRZ receiver, majority of three samples.
  always_ff @(posedge CLK) begin
    if (SYS_RST || !re_reg) begin
      rx_state_reg <= RX_IDLE;
      rx_scnt_reg  <= 4'h0;
      rx_bcnt_reg  <= 4'h0;
      rx_ones_reg  <= 2'h0;
      rx_noise_reg <= 1'b0;
      rx_shift_reg <= 9'h000;
    end else if (tick) begin
      rx_scnt_reg <= rx_scnt_reg + 4'h1;
      if (rx_scnt_reg == `SAMPLE_A || rx_scnt_reg == `SAMPLE_B || rx_scnt_reg == `SAMPLE_C) begin
        rx_ones_reg <= rx_ones_reg + {1'b0, rx_sync_reg};
      end
      if (rx_scnt_reg == `OVS_LAST) begin
        rx_ones_reg <= 2'h0;
      end
      case (rx_state_reg)
        RX_IDLE: begin
          rx_scnt_reg <= 4'h0;
          rx_ones_reg <= 2'h0;
          if (!rx_sync_reg) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rx_scnt_reg == `OVS_LAST) begin
            rx_state_reg <= bit_val ? RX_IDLE : RX_DATA;
            rx_bcnt_reg  <= 4'h0;
            rx_noise_reg <= bit_noisy;
          end
        end
        RX_DATA: begin
          if (rx_scnt_reg == `OVS_LAST) begin
            rx_shift_reg <= {bit_val, rx_shift_reg[8:1]};
            rx_noise_reg <= rx_noise_reg || bit_noisy;
            rx_bcnt_reg  <= rx_bcnt_reg + 4'h1;
            if (rx_bcnt_reg == (nine_reg ? `DATA_LAST_9 : `DATA_LAST_8)) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_scnt_reg == `OVS_LAST) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Parity inserted into the data character's top bit.
  logic [8:0] tx_char;
  always_comb begin
    tx_char = tx_hold_reg;
    if (par_en_reg && nine_reg) begin
      tx_char[8] = (^tx_hold_reg[7:0]) ^ par_odd_reg;
    end else if (par_en_reg) begin
      tx_char[7] = (^tx_hold_reg[6:0]) ^ par_odd_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_state_reg <= TX_IDLE;
      tx_scnt_reg  <= 4'h0;
      tx_bcnt_reg  <= 4'h0;
      tx_shift_reg <= 11'h7FF;
    end else if (tick) begin
      tx_scnt_reg <= tx_scnt_reg + 4'h1;
      case (tx_state_reg)
        TX_IDLE: begin
          tx_scnt_reg <= 4'h0;
          tx_bcnt_reg <= 4'h0;
          if (te_reg && sbk_reg) begin
            tx_state_reg <= TX_BREAK;
          end else if (tx_load) begin
            tx_state_reg <= TX_SHIFT;
            tx_shift_reg <= {1'b1, nine_reg ? tx_char[8] : 1'b1, tx_char[7:0], 1'b0};
          end
        end
        TX_SHIFT, TX_BREAK: begin
          if (tx_scnt_reg == `OVS_LAST) begin
            tx_bcnt_reg  <= tx_bcnt_reg + 4'h1;
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            if (tx_end) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      txd_reg <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_SHIFT: txd_reg <= tx_shift_reg[0] ^ tx_inv_reg;
        TX_BREAK: txd_reg <= tx_inv_reg;
        default:  txd_reg <= !tx_inv_reg;
      endcase
    end
  end
  assign TXD = txd_reg;

  // Read data multiplexer.
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (AVS_ADDRESS)
      `ADDR_DIV_HIGH: rdata_next[7:0] = {brk_ie_reg, edge_ie_reg, 1'b0, div_hi_reg};
      `ADDR_DIV_LOW:  rdata_next[7:0] = div_lo_reg;
      `ADDR_CTRL_ONE: rdata_next[7:0] = {3'h0, nine_reg, wake_addr_reg, 1'b0,
                                         par_en_reg, par_odd_reg};
      `ADDR_CTRL_TWO: rdata_next[7:0] = {tie_reg, tcie_reg, rie_reg, 1'b0, te_reg,
                                         re_reg, rwu_reg, sbk_reg};
      `ADDR_STAT_ONE: rdata_next[7:0] = {tdre_reg, tc_reg, rdrf_reg, idle_reg, ovr_reg,
                                         noise_reg, frame_reg, par_reg};
      `ADDR_STAT_TWO: rdata_next[7:0] = {brk_flag_reg, edge_flag_reg, 1'b0, tx_inv_reg,
                                         2'h0, brk_long_reg, rx_state_reg != RX_IDLE};
      `ADDR_DATA:     rdata_next[8:0] = rx_data_reg;
      default:        rdata_next = 32'h0000_0000;
    endcase
  end

  // Read answer one cycle after the request.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_ack_reg   <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      rd_ack_reg <= rd_en;
      if (rd_en) begin
        AVS_READDATA <= rdata_next;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (brk_ie_reg && brk_flag_reg) || (edge_ie_reg && edge_flag_reg)
             || (tie_reg && tdre_reg) || (tcie_reg && tc_reg) || (rie_reg && rdrf_reg);
    end
  end

  // per-instance generator and divisor live in this module.
endmodule : uart_baud_top

// File: verilog/uart_baud_defs.svh
// Register map, field positions, reset values and bit timing counts of the serial port.
// Included by the serial port modules; holds definitions only.
`ifndef UART_BAUD_DEFS_SVH
`define UART_BAUD_DEFS_SVH

`define DIV_WIDTH        13
`define ADDR_WIDTH       5
`define ADDR_DIV_HIGH    5'h00
`define ADDR_DIV_LOW     5'h04
`define ADDR_CTRL_ONE    5'h08
`define ADDR_CTRL_TWO    5'h0C
`define ADDR_STAT_ONE    5'h10
`define ADDR_STAT_TWO    5'h14
`define ADDR_DATA        5'h18

`define DIV_LOW_RESET    8'h04
`define DIV_HIGH_RESET   5'h00

`define HI_BRK_IE        7
`define HI_EDGE_IE       6
`define C1_NINE          4
`define C1_WAKE_ADDR     3
`define C1_PAR_EN        1
`define C1_PAR_ODD       0
`define C2_TIE           7
`define C2_TCIE          6
`define C2_RIE           5
`define C2_TE            3
`define C2_RE            2
`define C2_RWU           1
`define C2_SBK           0
`define S1_TDRE          7
`define S1_TC            6
`define S1_RDRF          5
`define S1_IDLE          4
`define S1_OVR           3
`define S1_NOISE         2
`define S1_FRAME         1
`define S1_PAR           0
`define S2_BRK_FLAG      7
`define S2_EDGE_FLAG     6
`define S2_TX_INV        4
`define S2_BRK_LONG      1
`define S2_RX_ACTIVE     0

`define OVS_LAST         4'hF
`define SAMPLE_A         4'h7
`define SAMPLE_B         4'h8
`define SAMPLE_C         4'h9
`define FRAME_BITS_8     4'hA
`define FRAME_BITS_9     4'hB
`define BREAK_TX_SHORT   4'hA
`define BREAK_TX_LONG    4'hD
`define DATA_LAST_8      4'h7
`define DATA_LAST_9      4'h8
`define BREAK_RX_TICKS   8'hB0
`define IDLE_TICKS_8     8'hA0
`define IDLE_TICKS_9     8'hB0

`endif

// File: verilog/uart_baud_pkg.sv
// Types shared by the serial port modules.
// Assumes nothing of its surroundings.
package uart_baud_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} tx_state_e;
endpackage : uart_baud_pkg

// File: verilog/uart_baud_gen.sv
// Modulo baud generator: one tick per divisor clocks, sixteen ticks per bit.
// Assumes a synchronous active high reset on the same clock.
`timescale 1ns/1ps
`include "uart_baud_defs.svh"
module uart_baud_gen #(
  parameter int DIV_W = `DIV_WIDTH
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Control.
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  // Sixteen times oversampling tick.
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || !run || divisor == '0) begin
      cnt_reg <= DIV_W'(1);
      tick    <= 1'b0;
    end else if (cnt_reg >= divisor) begin
      cnt_reg <= DIV_W'(1);
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + DIV_W'(1);
      tick    <= 1'b0;
    end
  end
endmodule : uart_baud_gen

// File: dv/uart_peer.sv
// Remote serial node that sends and receives 8-bit NRZ characters.
// Assumes the bench clock and a bit length of BITC clock cycles.
`timescale 1ns/1ps
module uart_peer #(
  parameter int BITC = 32
) (
  // Clock.
  input  wire logic clk,
  // Serial line.
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BITC - 1) @(posedge clk);
    end
  endtask : send
  task automatic recv(output logic [7:0] d);
    do @(posedge clk); while (txd);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge clk);
      d[i] = txd;
    end
  endtask : recv
  task automatic hold_low(input int n);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask : hold_low
endmodule : uart_peer

// File: dv/uart_baud_top_props.sv
// Checker of bus answers, divisor readback, bit timing and interrupt.
// Assumes it is bound to the serial port top module.
`timescale 1ns/1ps
`include "uart_baud_defs.svh"
module uart_baud_top_props (
  input wire logic                   CLK,
  input wire logic                   SYS_RST,
  input wire logic [`ADDR_WIDTH-1:0] AVS_ADDRESS,
  input wire logic                   AVS_READ,
  input wire logic                   AVS_WRITE,
  input wire logic [31:0]            AVS_WRITEDATA,
  input wire logic [3:0]             AVS_BYTEENABLE,
  input wire logic [31:0]            AVS_READDATA,
  input wire logic                   AVS_WAITREQUEST,
  input wire logic                   TXD,
  input wire logic                   IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic [12:0] div_reg;
  logic [4:0]  hib_reg;
  logic [1:0]  hiw_reg;
  logic [2:0]  c2e_reg;
  logic        go_reg;
  logic [15:0] low_reg;
  logic        wr;
  logic        ans;
  assign wr = AVS_WRITE && AVS_BYTEENABLE[0];
  assign ans = AVS_READ && !AVS_WAITREQUEST;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_reg <= 13'h0004;
      hib_reg <= 5'h00;
      hiw_reg <= 2'h0;
      c2e_reg <= 3'h0;
      go_reg  <= 1'b0;
    end else if (wr) begin
      if (AVS_ADDRESS == `ADDR_DIV_HIGH) begin
        hib_reg <= AVS_WRITEDATA[4:0];
        hiw_reg <= AVS_WRITEDATA[7:6];
      end
      if (AVS_ADDRESS == `ADDR_DIV_LOW) div_reg <= {hib_reg, AVS_WRITEDATA[7:0]};
      if (AVS_ADDRESS == `ADDR_CTRL_TWO) begin
        c2e_reg <= AVS_WRITEDATA[7:5];
        go_reg  <= go_reg | AVS_WRITEDATA[3] | AVS_WRITEDATA[2];
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST || TXD) low_reg <= 16'h0000;
    else low_reg <= low_reg + 16'h0001;
  end
  a_read_answer: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("read answer not on second cycle");
  a_write_nowait: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("write stalled");
  a_high_read: assert property (ans && AVS_ADDRESS == `ADDR_DIV_HIGH |->
    AVS_READDATA[5:0] == {1'b0, div_reg[12:8]} && AVS_READDATA[31:8] == 24'h0)
    else $error("high divisor readback wrong");
  a_low_read: assert property (ans && AVS_ADDRESS == `ADDR_DIV_LOW |->
    AVS_READDATA == {24'h0, div_reg[7:0]}) else $error("low divisor readback wrong");
  a_bit_length: assert property ($rose(TXD) && div_reg != 13'h0 |->
    (int'(low_reg) % (16 * int'(div_reg))) == 0) else $error("low run not whole bits");
  a_gen_idle: assert property (!go_reg |-> TXD)
    else $error("line active before enable");
  a_zero_stop: assert property (div_reg == 13'h0 && $past(div_reg) == 13'h0 |-> $stable(TXD))
    else $error("line moved with zero divisor");
  a_irq_none: assert property (c2e_reg == 3'h0 && hiw_reg == 2'h0 &&
    $past(hiw_reg) == 2'h0 && $past(c2e_reg) == 3'h0 |-> !IRQ)
    else $error("interrupt without enable");
endmodule : uart_baud_top_props
bind uart_baud_top uart_baud_top_props chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TXD(TXD), .IRQ(IRQ));

// File: dv/tb_uart_baud_top.sv
// Bench for the serial port: register access, divisor, duplex traffic, interrupt.
// Assumes the remote node model and a divisor of two during traffic.
`timescale 1ns/1ps
`include "uart_baud_defs.svh"
module tb_uart_baud_top;
  logic        CLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, RXD, TXD, IRQ;
  logic [4:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [7:0]  got;
  int          n_fail, checks;
  uart_baud_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(4'h1), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
  uart_peer #(.BITC(32)) peer (.clk(CLK), .txd(TXD), .rxd(RXD));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE     <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST);
    AVS_WRITE <= 1'b0;
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_READ    <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST);
    chk(nm, e, AVS_READDATA);
    AVS_READ <= 1'b0;
  endtask : rc
  task automatic t_reset;
    rc(`ADDR_DIV_LOW, 32'h4, "div low");
    rc(`ADDR_DIV_HIGH, 32'h0, "div high");
    rc(5'h1C, 32'h0, "unmapped");
    repeat (100) @(posedge CLK);
    chk("txd idle", 32'h1, {31'h0, TXD});
  endtask : t_reset
  task automatic t_pair;
    wr(`ADDR_DIV_HIGH, 8'h3F);
    rc(`ADDR_DIV_HIGH, 32'h0, "buffered high");
    wr(`ADDR_DIV_LOW, 8'h02);
    rc(`ADDR_DIV_HIGH, 32'h1F, "applied high");
    rc(`ADDR_DIV_LOW, 32'h2, "applied low");
    wr(`ADDR_DIV_HIGH, 8'h00);
    wr(`ADDR_DIV_LOW, 8'h02);
  endtask : t_pair
  task automatic t_duplex;
    wr(`ADDR_CTRL_TWO, 8'h0C);
    wr(`ADDR_DATA, 8'hA5);
    fork
      peer.send(8'h3C);
      peer.recv(got);
    join
    chk("tx char", 32'hA5, {24'h0, got});
    repeat (64) @(posedge CLK);
    rc(`ADDR_STAT_ONE, 32'hE0, "status");
    rc(`ADDR_DATA, 32'h3C, "rx char");
  endtask : t_duplex
  task automatic t_edge;
    wr(`ADDR_STAT_TWO, 8'h40);
    wr(`ADDR_DIV_HIGH, 8'h40);
    wr(`ADDR_DIV_LOW, 8'h02);
    repeat (2) @(posedge CLK);
    chk("irq before edge", 32'h0, {31'h0, IRQ});
    fork peer.send(8'hFF); join_none
    repeat (8) @(posedge CLK);
    chk("irq on", 32'h1, {31'h0, IRQ});
    wait fork;
    wr(`ADDR_STAT_TWO, 8'h40);
    repeat (2) @(posedge CLK);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
    wr(`ADDR_DIV_HIGH, 8'h00);
    wr(`ADDR_DIV_LOW, 8'h02);
    peer.send(8'hFF);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    repeat (16) @(posedge CLK);
    rc(`ADDR_STAT_TWO, 32'h40, "edge flag");
  endtask : t_edge
  task automatic t_brk;
    wr(`ADDR_DIV_HIGH, 8'h80);
    wr(`ADDR_DIV_LOW, 8'h02);
    repeat (2) @(posedge CLK);
    chk("irq no break", 32'h0, {31'h0, IRQ});
    peer.hold_low(400);
    chk("irq on break", 32'h1, {31'h0, IRQ});
  endtask : t_brk
  task automatic t_zero;
    wr(`ADDR_DIV_LOW, 8'h00);
    wr(`ADDR_DATA, 8'h55);
    repeat (200) @(posedge CLK);
    chk("txd stopped", 32'h1, {31'h0, TXD});
    fork
      wr(`ADDR_DIV_LOW, 8'h02);
      peer.recv(got);
    join
    chk("tx resumed", 32'h55, {24'h0, got});
  endtask : t_zero
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    complete_run();
  end
  initial begin
    {SYS_RST, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = {3'b100, 37'h0};
    repeat (16) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_pair();
    t_duplex();
    t_edge();
    t_brk();
    t_zero();
    complete_run();
  end
endmodule : tb_uart_baud_top
